// ===== include/qsw_params.svh
`ifndef QSW_PARAMS_SVH
`define QSW_PARAMS_SVH

// ****************************************
// Clock and interval timing
// ****************************************
`define CLK_PERIOD_NS          20
`define LIMIT_RATE_NS_PER_PF   1280
`define CYCLES_PER_PF          (`LIMIT_RATE_NS_PER_PF / `CLK_PERIOD_NS)
`define OFF_DEFAULT_MULT       64
`define CAP_MIN_PF             50
`define CAP_MAX_PF             15000

// ****************************************
// Reset values and channel count
// ****************************************
`define SUPPLY_LOW_RESET       1'b1
`define OVERTEMP_RESET         1'b0
`define CHANNELS               4

`endif

// ===== include/qsw_pkg.sv
package qsw_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {LIM_NORMAL, LIM_ON, LIM_OFF} limit_state_type;
  typedef logic [13:0] cap_type;
  typedef logic [25:0] count_type;
  typedef logic [6:0]  rate_type;

endpackage

// ===== design/sync2.sv
`timescale 1ns/100ps

module sync2
  import qsw_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         MCLK,    // System clock
  input  wire logic         SYS_RST, // Async reset, active high
  input  wire logic [W-1:0] D,       // Asynchronous level
  output logic      [W-1:0] Q        // Synchronised level
);

  logic [W-1:0] meta_q;

  // Meta stage read only by the second stage
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      meta_q <= '0;
      Q      <= '0;
    end
    else
    begin
      meta_q <= D;
      Q      <= meta_q;
    end
  end

endmodule

// ===== design/hyst_latch.sv
`timescale 1ns/100ps

module hyst_latch
  import qsw_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  input  wire logic MCLK,    // System clock
  input  wire logic SYS_RST, // Async reset, active high
  input  wire logic SET,     // Crossed the raising threshold
  input  wire logic CLR,     // Crossed the releasing threshold
  output logic      FLAG     // Hysteretic flag
);

  // Set wins, so a fault seen together with release is kept
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      FLAG <= RESET_VAL;
    else if (SET)
      FLAG <= 1'b1;
    else if (CLR)
      FLAG <= 1'b0;
  end

endmodule

// ===== design/quad_switch_fault_protection.sv
// Operation
// - Overtemperature switches all outputs off and asserts the diagnostic flag.
// - Overtemperature releases only below the limit minus hysteresis.
// - Supply-low stays active until supply exceeds the upper threshold.
// - Supply-low returns only below upper threshold minus hysteresis.
// - Supply-low forces outputs off and asserts the flag; nothing else is disturbed.
// - Open-drain active-low flag shows limiting, supply-low or overtemperature.
// - Four independent limit channels; one short leaves others untouched.
// - On a short the channel stays on for the on interval.
// - Short still present after on interval: output off for off interval.
// - After off interval: retry if short persists, else normal control.
// - Intervals set independently, 1.28 us per pF, 50 pF to 15 nF.
// - Off setting grounded: off interval is sixty-four on intervals.
// - Flag asserted while limited output is off, not during on interval.
// - Both settings grounded: no timed protection, shorted outputs stay on.
// - Protection inhibited: flag ignores shorts, still shows other faults.
// - Flag delayed by the on interval after limiting begins.
// - Hold-off input low forces all outputs low asynchronously.
`timescale 1ns/100ps
`include "qsw_params.svh"

module quad_switch_fault_protection
  import qsw_pkg::*;
#(
  parameter rate_type CYCLES_PER_PF = rate_type'(`CYCLES_PER_PF)
)
(
  input  wire logic        MCLK,                // System clock, 50 MHz
  input  wire logic        SYS_RST,             // Async reset, active high
  input  wire logic        HOLD_OFF_N,          // Async output hold-off, low active
  input  wire logic [3:0]  CHAN_IN,             // Channel command pins
  input  wire logic [3:0]  SHORT_DET,           // Per-channel short detected
  input  wire logic        TEMP_OVER_LIMIT,     // Temperature above limit
  input  wire logic        TEMP_OVER_RELEASE,   // Temperature above limit minus hyst
  input  wire logic        SUPPLY_OVER_UPPER,   // Supply above upper threshold
  input  wire logic        SUPPLY_OVER_LOWER,   // Supply above upper minus hyst
  input  wire logic [13:0] ON_CAP_PF,           // On interval setting, 0 = grounded
  input  wire logic [13:0] OFF_CAP_PF,          // Off interval setting, 0 = grounded
  output logic      [3:0]  CHAN_OUT,            // Switched outputs
  output logic             DIAG_N_O,            // Diagnostic pin level when driven
  output logic             DIAG_N_OE,           // Diagnostic pulled low while high
  output logic             OVERTEMP_CONDITION,  // Overtemperature flag
  output logic             SUPPLY_LOW,          // Undervoltage flag
  output logic      [3:0]  OVERCURRENT_ACTIVE   // Channel in timed limit cycle
);

  // ****************************************
  // Functions
  // ****************************************
  // Nonzero settings outside the supported range are clamped to it; zero gives one cycle
  function automatic count_type interval_cycles(input cap_type pf, input rate_type rate);
    cap_type c;
    c = pf;
    if (c < cap_type'(`CAP_MIN_PF))
      c = cap_type'(`CAP_MIN_PF);
    if (c > cap_type'(`CAP_MAX_PF))
      c = cap_type'(`CAP_MAX_PF);
    if (pf == '0)
      interval_cycles = count_type'(1);
    else
      interval_cycles = count_type'(count_type'(c) * count_type'(rate));
  endfunction

  // ****************************************
  // Synchronisers
  // ****************************************
  logic [3:0] in_s;
  logic [3:0] short_s;
  logic       temp_hi_s;
  logic       temp_rel_s;
  logic       sup_up_s;
  logic       sup_lo_s;

  sync2 #(.W(12)) u_sync
  (
    .MCLK    (MCLK),
    .SYS_RST (SYS_RST),
    .D       ({CHAN_IN, SHORT_DET, TEMP_OVER_LIMIT, TEMP_OVER_RELEASE,
               SUPPLY_OVER_UPPER, SUPPLY_OVER_LOWER}),
    .Q       ({in_s, short_s, temp_hi_s, temp_rel_s, sup_up_s, sup_lo_s})
  );

  // ****************************************
  // Overtemperature and supply-low flags
  // ****************************************
  logic hot_flag;
  logic low_supply_flag;
  wire  hot_clr        = !temp_rel_s;
  wire  low_supply_set = !sup_lo_s;

  hyst_latch #(.RESET_VAL(`OVERTEMP_RESET)) u_hot
  (
    .MCLK    (MCLK),
    .SYS_RST (SYS_RST),
    .SET     (temp_hi_s),
    .CLR     (hot_clr),
    .FLAG    (hot_flag)
  );

  // Active from reset until the supply first clears the upper threshold
  hyst_latch #(.RESET_VAL(`SUPPLY_LOW_RESET)) u_low_supply
  (
    .MCLK    (MCLK),
    .SYS_RST (SYS_RST),
    .SET     (low_supply_set),
    .CLR     (sup_up_s),
    .FLAG    (low_supply_flag)
  );

  // ****************************************
  // Interval decode
  // ****************************************
  wire       inhibit     = (ON_CAP_PF == '0) && (OFF_CAP_PF == '0);
  count_type on_cycles;
  count_type off_cycles;
  assign on_cycles  = interval_cycles(ON_CAP_PF, CYCLES_PER_PF);
  assign off_cycles = (OFF_CAP_PF == '0)
                    ? count_type'(on_cycles * count_type'(`OFF_DEFAULT_MULT))
                    : interval_cycles(OFF_CAP_PF, CYCLES_PER_PF);

  // ****************************************
  // Per-channel limit sequencers
  // ****************************************
  limit_state_type state_q [4];
  limit_state_type state_d [4];
  count_type       cnt_q [4];
  count_type       cnt_d [4];
  logic [3:0]      off_phase;
  logic [3:0]      in_limit;
  logic [3:0]      out_d;

  // Each channel has its own state and counter, no shared term
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_chan
      always_comb
      begin
        state_d[gi] = state_q[gi];
        cnt_d[gi]   = cnt_q[gi];
        case (state_q[gi])
          LIM_NORMAL:
          begin
            if (!inhibit && short_s[gi] && CHAN_OUT[gi])
            begin
              state_d[gi] = LIM_ON;
              cnt_d[gi]   = on_cycles - count_type'(1);
            end
          end
          LIM_ON:
          begin
            if (inhibit || !short_s[gi])
              state_d[gi] = LIM_NORMAL;
            else if (cnt_q[gi] == '0)
            begin
              state_d[gi] = LIM_OFF;
              cnt_d[gi]   = off_cycles - count_type'(1);
            end
            else
              cnt_d[gi] = cnt_q[gi] - count_type'(1);
          end
          LIM_OFF:
          begin
            if (inhibit)
              state_d[gi] = LIM_NORMAL;
            else if (cnt_q[gi] == '0)
            begin
              if (short_s[gi])
              begin
                state_d[gi] = LIM_ON;
                cnt_d[gi]   = on_cycles - count_type'(1);
              end
              else
                state_d[gi] = LIM_NORMAL;
            end
            else
              cnt_d[gi] = cnt_q[gi] - count_type'(1);
          end
          default:
          begin
            state_d[gi] = LIM_NORMAL;
            cnt_d[gi]   = '0;
          end
        endcase
      end

      always_ff @(posedge MCLK or posedge SYS_RST)
      begin
        if (SYS_RST)
        begin
          state_q[gi] <= LIM_NORMAL;
          cnt_q[gi]   <= '0;
        end
        else
        begin
          state_q[gi] <= state_d[gi];
          cnt_q[gi]   <= cnt_d[gi];
        end
      end

      assign off_phase[gi] = (state_q[gi] == LIM_OFF);
      assign in_limit[gi]  = (state_q[gi] != LIM_NORMAL);
      // Faults gate the command; the on phase keeps the output driven
      assign out_d[gi] = in_s[gi] && !hot_flag && !low_supply_flag && !off_phase[gi];
    end
  endgenerate

  // ****************************************
  // Outputs
  // ****************************************
  // The flag ignores the on phase, which also filters brief inrush limiting
  wire diag_d = hot_flag || low_supply_flag || (|off_phase);

  // Hold-off clears straight through the flops, so it needs no clock
  always_ff @(posedge MCLK or posedge SYS_RST or negedge HOLD_OFF_N)
  begin
    if (SYS_RST)
      CHAN_OUT <= '0;
    else if (!HOLD_OFF_N)
      CHAN_OUT <= '0;
    else
      CHAN_OUT <= out_d;
  end

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      DIAG_N_O           <= 1'b0;
      DIAG_N_OE          <= 1'b0;
      OVERTEMP_CONDITION <= `OVERTEMP_RESET;
      SUPPLY_LOW         <= `SUPPLY_LOW_RESET;
      OVERCURRENT_ACTIVE <= '0;
    end
    else
    begin
      DIAG_N_O           <= 1'b0;
      DIAG_N_OE          <= diag_d;
      OVERTEMP_CONDITION <= hot_flag;
      SUPPLY_LOW         <= low_supply_flag;
      OVERCURRENT_ACTIVE <= in_limit;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  // Per-channel checks watch channel 1, the one a short is put on
  logic [25:0] on_len_q;

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      on_len_q <= '0;
    else if (state_q[1] == LIM_ON)
      on_len_q <= on_len_q + 26'h0000001;
    else
      on_len_q <= '0;
  end

  a_hot_outputs_off:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      hot_flag |=> (CHAN_OUT == 4'h0) && DIAG_N_OE)
    else $error("outputs or flag wrong during overtemperature");

  a_low_outputs_off:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      low_supply_flag |=> (CHAN_OUT == 4'h0) && DIAG_N_OE)
    else $error("outputs or flag wrong during supply-low");

  a_low_hyst_hold:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (!low_supply_flag && sup_lo_s) |=> !low_supply_flag)
    else $error("supply-low raised above lower threshold");

  a_hot_release:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (hot_flag && temp_rel_s && !temp_hi_s) |=> hot_flag)
    else $error("overtemperature released above release level");

  a_on_time_len:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (state_q[1] == LIM_ON && state_d[1] == LIM_OFF)
        |-> (on_len_q + 26'h0000001 == on_cycles))
    else $error("on interval length wrong");

  a_off_flagged:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (state_q[1] == LIM_OFF) |=> DIAG_N_OE && !CHAN_OUT[1])
    else $error("off phase not flagged or output on");

  a_on_not_flagged:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (!hot_flag && !low_supply_flag && off_phase == 4'h0) |=> !DIAG_N_OE)
    else $error("flag raised without off phase or fault");

  a_retry_restart:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (state_q[1] == LIM_OFF && cnt_q[1] == '0 && short_s[1] && !inhibit)
        |=> (state_q[1] == LIM_ON) && (cnt_q[1] == $past(on_cycles) - count_type'(1)))
    else $error("retry did not restart the on interval");

  a_off_default:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (OFF_CAP_PF == '0) |-> (off_cycles == count_type'(on_cycles * 26'h0000040)))
    else $error("default off interval is not 64 on intervals");

  a_inhibit_idle:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (inhibit && state_q[1] == LIM_NORMAL) |=> (state_q[1] == LIM_NORMAL))
    else $error("timed protection ran while inhibited");

  a_holdoff_low:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      !HOLD_OFF_N |-> (CHAN_OUT == 4'h0))
    else $error("output high during hold-off");

  a_follow_input:
    assert property (@(posedge MCLK) disable iff (SYS_RST || !HOLD_OFF_N)
      (!hot_flag && !low_supply_flag && off_phase == 4'h0) |=> (CHAN_OUT == $past(in_s)))
    else $error("output does not follow its input");

endmodule

// ===== tb/load_model.sv
`timescale 1ns/100ps

module load_model
#(
  parameter int TEMP_LIMIT_C  = 150,
  parameter int TEMP_HYST_C   = 20,
  parameter int SUPPLY_UP_MV  = 9000,
  parameter int SUPPLY_HYS_MV = 500
)
(
  input  wire logic [3:0] short_mask,   // Loads wired as shorts
  input  int              temp_c,       // Die temperature
  input  int              supply_mv,    // Supply level
  input  wire logic       diag_n_o,     // Diagnostic drive level
  input  wire logic       diag_n_oe,    // Diagnostic drive enable
  output logic      [3:0] short_det,    // Short seen per channel
  output logic            t_lim,        // Above temperature limit
  output logic            t_rel,        // Above limit minus hysteresis
  output logic            s_up,         // Above upper supply threshold
  output logic            s_lo,         // Above upper minus hysteresis
  output logic            diag_pin      // Wired-OR diagnostic line
);
  // A shorted load stays shorted while the switch is off too
  assign short_det = short_mask;
  assign t_lim     = temp_c > TEMP_LIMIT_C;
  assign t_rel     = temp_c > TEMP_LIMIT_C - TEMP_HYST_C;
  assign s_up      = supply_mv > SUPPLY_UP_MV;
  assign s_lo      = supply_mv > SUPPLY_UP_MV - SUPPLY_HYS_MV;
  // Pull-up holds the line high when released
  assign diag_pin  = diag_n_oe ? diag_n_o : 1'b1;
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps

module tb;
  import qsw_pkg::*;
  localparam int T_ON  = 50;
  localparam int T_OFF = 100;
  logic        mclk, sys_rst, hold_off_n, t_lim, t_rel, s_up, s_lo;
  logic        diag_n_o, diag_n_oe, overtemp, supply_low, diag_pin;
  logic [3:0]  chan_in, short_mask, short_det, chan_out, oc;
  logic [13:0] on_cap, off_cap;
  int          temp_c, supply_mv, mismatches, checks_done, n, m;

  quad_switch_fault_protection #(.CYCLES_PER_PF(rate_type'(1))) quad_switch_fault_protection_i (
    .MCLK(mclk), .SYS_RST(sys_rst), .HOLD_OFF_N(hold_off_n), .CHAN_IN(chan_in),
    .SHORT_DET(short_det), .TEMP_OVER_LIMIT(t_lim), .TEMP_OVER_RELEASE(t_rel),
    .SUPPLY_OVER_UPPER(s_up), .SUPPLY_OVER_LOWER(s_lo), .ON_CAP_PF(on_cap),
    .OFF_CAP_PF(off_cap), .CHAN_OUT(chan_out), .DIAG_N_O(diag_n_o), .DIAG_N_OE(diag_n_oe),
    .OVERTEMP_CONDITION(overtemp), .SUPPLY_LOW(supply_low), .OVERCURRENT_ACTIVE(oc));

  load_model load_model_i (
    .short_mask(short_mask), .temp_c(temp_c), .supply_mv(supply_mv), .diag_n_o(diag_n_o),
    .diag_n_oe(diag_n_oe), .short_det(short_det), .t_lim(t_lim), .t_rel(t_rel),
    .s_up(s_up), .s_lo(s_lo), .diag_pin(diag_pin));

  // ****************************************
  // Bench tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask

  // Bounded wait on output 1 (sel 0) or its limit flag (sel 1)
  task automatic wait_bit(input int sel, input logic lvl, output int cnt);
    cnt = 0;
    while ((sel == 0 ? chan_out[1] : oc[1]) !== lvl && cnt < 5000)
    begin
      tick(1);
      cnt++;
    end
    if (cnt >= 5000)
      mismatches++;
  endtask

  task automatic near(input string what, input int seen, input int exp);
    check(what, 32'(seen >= exp - 2 && seen <= exp + 2), 32'h1);
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Whole run is a few thousand cycles; this leaves ample margin
  initial
  begin
    #(20 * 12000);
    mismatches++;
    complete_run();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    mismatches = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    hold_off_n = 1'b1;
    chan_in = 4'hF;
    short_mask = 4'h0;
    on_cap = 14'h0032;
    off_cap = 14'h0064;
    temp_c = 25;
    supply_mv = 8000;
    tick(6);
    sys_rst = 1'b0;
    tick(8);
    check("supply_low", supply_low, 32'h1);
    check("diag", diag_pin, 32'h0);
    check("chan_out", chan_out, 32'h0);
    supply_mv = 8800;
    tick(8);
    check("supply_low", supply_low, 32'h1);
    supply_mv = 9500;
    tick(8);
    check("supply_low", supply_low, 32'h0);
    check("diag", diag_pin, 32'h1);
    check("chan_out", chan_out, 32'hF);
    supply_mv = 8800;
    tick(8);
    check("supply_low", supply_low, 32'h0);
    supply_mv = 8400;
    tick(8);
    check("supply_low", supply_low, 32'h1);
    check("chan_out", chan_out, 32'h0);
    check("diag", diag_pin, 32'h0);
    supply_mv = 9500;
    chan_in = 4'hA;
    tick(8);
    check("chan_out", chan_out, 32'hA);
    $display("Supply test done");
    hold_off_n = 1'b0;
    #1;
    check("chan_out", chan_out, 32'h0);
    tick(4);
    check("chan_out", chan_out, 32'h0);
    hold_off_n = 1'b1;
    chan_in = 4'hF;
    tick(8);
    temp_c = 160;
    tick(8);
    check("overtemp", overtemp, 32'h1);
    check("chan_out", chan_out, 32'h0);
    check("diag", diag_pin, 32'h0);
    temp_c = 140;
    tick(8);
    check("overtemp", overtemp, 32'h1);
    temp_c = 120;
    tick(8);
    check("overtemp", overtemp, 32'h0);
    check("chan_out", chan_out, 32'hF);
    $display("Hold-off and temperature test done");
    short_mask = 4'h2;
    wait_bit(1, 1'b1, n);
    check("oc_start", 32'(n <= 8), 32'h1);
    tick(T_ON / 2);
    check("chan_out", chan_out, 32'hF);
    check("diag", diag_pin, 32'h1);
    wait_bit(0, 1'b0, m);
    near("on_time", m + T_ON / 2, T_ON);
    tick(1);
    check("diag", diag_pin, 32'h0);
    check("chan_out", chan_out, 32'hD);
    check("oc", oc, 32'h2);
    wait_bit(0, 1'b1, n);
    near("off_time", n + 1, T_OFF);
    short_mask = 4'h0;
    tick(8);
    check("oc", oc, 32'h0);
    check("chan_out", chan_out, 32'hF);
    check("diag", diag_pin, 32'h1);
    off_cap = 14'h0000;
    on_cap = 14'h000A;  // Below range, clamps to the minimum
    short_mask = 4'h2;
    wait_bit(0, 1'b0, n);
    wait_bit(0, 1'b1, n);
    near("off_default", n, 64 * T_ON);
    short_mask = 4'h0;
    tick(8);
    $display("Short cycle test done");
    on_cap = 14'h0000;
    short_mask = 4'h2;
    tick(200);
    check("chan_out", chan_out, 32'hF);
    check("oc", oc, 32'h0);
    check("diag", diag_pin, 32'h1);
    temp_c = 160;
    tick(8);
    check("chan_out", chan_out, 32'h0);
    check("diag", diag_pin, 32'h0);
    $display("Inhibit test done");
    complete_run();
  end
endmodule
